// [design/cmi_mode_id.sv]
// Chip mode capture, identification registers and flash page select.
// Assumes an AXI4-Lite master on aclk and an asynchronous mode strap.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module cmi_mode_id
  import cmi_pkg::*;
#(
  parameter logic [3:0] FAM_MAJ  = 4'h1, // Arbitrary value
  parameter logic [5:0] FAM_MIN  = 6'h02, // Arbitrary value
  parameter logic [1:0] MASK_MAJ = 2'h0, // Arbitrary value
  parameter logic [3:0] MASK_MIN = 4'h1  // Arbitrary value
)(
  input  wire logic               aclk,             // System clock
  input  wire logic               aresetn,          // Sync reset, low
  input  wire logic [7:0]         s_axi_awaddr,     // Write address
  input  wire logic               s_axi_awvalid,    // Write address valid
  output logic                    s_axi_awready,    // Write address ready
  input  wire logic [31:0]        s_axi_wdata,      // Write data
  input  wire logic [3:0]         s_axi_wstrb,      // Write byte strobes
  input  wire logic               s_axi_wvalid,     // Write data valid
  output logic                    s_axi_wready,     // Write data ready
  output logic [1:0]              s_axi_bresp,      // Write response
  output logic                    s_axi_bvalid,     // Write response valid
  input  wire logic               s_axi_bready,     // Write response ready
  input  wire logic [7:0]         s_axi_araddr,     // Read address
  input  wire logic               s_axi_arvalid,    // Read address valid
  output logic                    s_axi_arready,    // Read address ready
  output logic [31:0]             s_axi_rdata,      // Read data
  output logic [1:0]              s_axi_rresp,      // Read response
  output logic                    s_axi_rvalid,     // Read data valid
  input  wire logic               s_axi_rready,     // Read data ready
  input  wire logic               mode_select_input, // Mode strap pin
  input  wire logic               cpu_addr_valid,   // Local access valid
  input  wire logic [LADDR_W-1:0] cpu_local_addr,   // Local address
  output cmi_xlate_t              flash_global,     // Global address out
  output logic                    mode_valid,       // Mode captured
  output logic                    mode_normal,      // Normal single chip
  output logic                    boot_internal,    // Fetch reset vector
  output logic                    debug_unit_active, // Debug unit enabled
  output logic                    boot_monitor_rom  // Run monitor ROM
);

  // ---------------------------------------------------------------
  // Fixed identifier
  // ---------------------------------------------------------------
  localparam logic [15:0] PART_ID =
    cmi_part_id(FAM_MAJ, FAM_MIN, MASK_MAJ, MASK_MIN);

  logic [7:0] identifier_high_byte;
  logic [7:0] identifier_low_byte;

  // Constant bytes, no storage that a write could reach
  assign identifier_high_byte = PART_ID[15:8];
  assign identifier_low_byte  = PART_ID[7:0];

  // ---------------------------------------------------------------
  // Strap synchroniser
  // ---------------------------------------------------------------
  logic strap_meta;
  logic strap_sync;

  // Free-running so the strap is settled when reset lifts
  // Only the second flop feeds the capture, never the first
  always_ff @(posedge aclk) begin
    strap_meta <= mode_select_input;
    strap_sync <= strap_meta;
  end

  // ---------------------------------------------------------------
  // Boot sequence and mode bit
  // ---------------------------------------------------------------
  cmi_boot_t boot_state;
  cmi_boot_t next_boot_state;
  logic      mode;
  logic      next_mode;
  logic      mode_wr;
  logic      mode_wr_val;

  // Capture the strap once after release, then allow software.
  // The hold state gives the synchroniser one clean edge after reset,
  // and mode writes that land before the run state are dropped.
  always_comb begin
    next_boot_state = boot_state;
    next_mode       = mode;
    unique case (boot_state)
      CMI_HOLD: begin
        next_boot_state = CMI_CAPTURE;
      end
      CMI_CAPTURE: begin
        next_mode       = strap_sync;
        next_boot_state = CMI_RUN;
      end
      CMI_RUN: begin
        // Only special mode may switch; normal mode is locked
        if (mode_wr && mode == MODE_SPECIAL) begin
          next_mode = mode_wr_val;
        end
      end
      default: begin
        next_boot_state = CMI_HOLD;
      end
    endcase
  end

  // Boot state registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_state <= CMI_HOLD;
      mode       <= MODE_RESET;
    end else begin
      boot_state <= next_boot_state;
      mode       <= next_mode;
    end
  end

  // Mode decode toward processor and debug unit
  assign mode_valid        = (boot_state == CMI_RUN);
  assign mode_normal       = mode_valid && (mode == MODE_NORMAL);
  assign boot_internal     = mode_normal;
  assign debug_unit_active = mode_valid && (mode == MODE_SPECIAL);
  assign boot_monitor_rom  = debug_unit_active;

  // ---------------------------------------------------------------
  // Flash page select
  // ---------------------------------------------------------------
  logic [PAGE_W-1:0] page;
  logic [PAGE_W-1:0] next_page;
  logic              page_wr;
  logic [PAGE_W-1:0] page_wr_val;

  // Byte-lane zero write updates the page
  always_comb begin
    next_page = page;
    if (page_wr) begin
      next_page = page_wr_val;
    end
  end

  // Page register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      page <= PAGE_RESET;
    end else begin
      page <= next_page;
    end
  end

  // Window translation for processor and debug accesses
  cmi_page_xlate u_xlate (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .req_valid  (cpu_addr_valid),
    .local_addr (cpu_local_addr),
    .page       (page),
    .xlate      (flash_global)
  );

  // ---------------------------------------------------------------
  // AXI4-Lite write path
  // ---------------------------------------------------------------
  cmi_wr_t    wr;
  cmi_wr_t    next_wr;
  logic       aw_held;
  logic       next_aw_held;
  logic       w_held;
  logic       next_w_held;
  logic       bvalid;
  logic       next_bvalid;
  logic [1:0] bresp;
  logic [1:0] next_bresp;
  logic       wr_go;

  // Address and data are taken in either order, one write at a time
  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready  = !w_held && !bvalid;
  assign wr_go         = aw_held && w_held && !bvalid;

  // Register decode of the held write
  // Identifier writes answer okay so software sees no fault
  always_comb begin
    mode_wr     = 1'b0;
    mode_wr_val = wr.data[MODE_BIT];
    page_wr     = 1'b0;
    page_wr_val = wr.data[PAGE_W-1:0];
    next_bresp  = RESP_OKAY;
    if (wr_go) begin
      unique case (wr.addr)
        ADDR_MODE:         mode_wr = wr.strb[0];
        ADDR_PAGE:         page_wr = wr.strb[0];
        ADDR_PART_ID_HIGH,
        ADDR_PART_ID_LOW:  next_bresp = RESP_OKAY;
        default:           next_bresp = RESP_SLVERR;
      endcase
    end
  end

  // Handshake bookkeeping for the write channels
  always_comb begin
    next_wr      = wr;
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_bvalid  = bvalid;
    if (s_axi_awvalid && s_axi_awready) begin
      next_wr.addr = s_axi_awaddr;
      next_aw_held = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wr.data = s_axi_wdata;
      next_wr.strb = s_axi_wstrb;
      next_w_held  = 1'b1;
    end
    if (wr_go) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  // Write path registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr      <= '0;
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
    end else begin
      wr      <= next_wr;
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      bvalid  <= next_bvalid;
      bresp   <= wr_go ? next_bresp : bresp;
    end
  end

  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp  = bresp;

  // ---------------------------------------------------------------
  // AXI4-Lite read path
  // ---------------------------------------------------------------
  logic        rvalid;
  logic        next_rvalid;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [1:0]  rresp;
  logic [1:0]  next_rresp;

  // One read at a time; data are answered the cycle after the address
  // Reads never wait on the write path; both may be under way at once
  assign s_axi_arready = !rvalid;

  // Read multiplexer and response
  always_comb begin
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata  = '0;
      next_rresp  = RESP_OKAY;
      unique case (s_axi_araddr)
        ADDR_PART_ID_HIGH: next_rdata[7:0] = identifier_high_byte;
        ADDR_PART_ID_LOW:  next_rdata[7:0] = identifier_low_byte;
        ADDR_MODE:         next_rdata[MODE_BIT] = mode;
        ADDR_PAGE:         next_rdata[PAGE_W-1:0] = page;
        default:           next_rresp = RESP_SLVERR;
      endcase
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // Read path registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= RESP_OKAY;
    end else begin
      rvalid <= next_rvalid;
      rdata  <= next_rdata;
      rresp  <= next_rresp;
    end
  end

  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata  = rdata;
  assign s_axi_rresp  = rresp;

endmodule : cmi_mode_id

// [pkg/cmi_pkg.sv]
// Constants, types and helpers for the chip mode and identification block.
// Assumes a 32-bit AXI4-Lite register bus with 8-bit byte addresses.
package cmi_pkg;

  // ---------------------------------------------------------------
  // Register indices and byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_PART_ID_HIGH = 8'h1a;
  localparam logic [7:0] IDX_PART_ID_LOW  = 8'h1b;
  localparam logic [7:0] IDX_MODE         = 8'h0b;
  localparam logic [7:0] IDX_PAGE         = 8'h15;

  // Byte address of a register from its word index
  function automatic logic [7:0] cmi_byte_addr(input logic [7:0] idx);
    cmi_byte_addr = {idx[5:0], 2'b00};
  endfunction : cmi_byte_addr

  localparam logic [7:0] ADDR_PART_ID_HIGH = cmi_byte_addr(IDX_PART_ID_HIGH);
  localparam logic [7:0] ADDR_PART_ID_LOW  = cmi_byte_addr(IDX_PART_ID_LOW);
  localparam logic [7:0] ADDR_MODE         = cmi_byte_addr(IDX_MODE);
  localparam logic [7:0] ADDR_PAGE         = cmi_byte_addr(IDX_PAGE);

  // ---------------------------------------------------------------
  // Mode field, page field and reset values
  // ---------------------------------------------------------------
  localparam int unsigned MODE_BIT     = 0;
  localparam logic        MODE_NORMAL  = 1'b1;
  localparam logic        MODE_SPECIAL = 1'b0;
  localparam logic        MODE_RESET   = 1'b0;
  localparam int unsigned PAGE_W       = 8;
  localparam int unsigned PAGE_USED_W  = 4;
  localparam logic [7:0]  PAGE_RESET   = 8'h00;

  // ---------------------------------------------------------------
  // Flash window translation
  // ---------------------------------------------------------------
  localparam int unsigned LADDR_W    = 16;
  localparam int unsigned WIN_OFS_W  = 14;
  localparam int unsigned GADDR_W    = 18;
  localparam logic [15:0] WIN_FIRST  = 16'h8000;
  localparam logic [15:0] WIN_LAST   = 16'hbfff;
  localparam logic [1:0]  FIXED_HIGH = 2'h3;

  // ---------------------------------------------------------------
  // Identifier field positions
  // ---------------------------------------------------------------
  localparam int unsigned ID_FAM_MAJ_LSB = 12;
  localparam int unsigned ID_FAM_MIN_LSB = 6;
  localparam int unsigned ID_MASK_MAJ_LSB = 4;
  localparam int unsigned ID_MASK_MIN_LSB = 0;

  // Assemble the 16-bit identifier from its four fields
  function automatic logic [15:0] cmi_part_id(input logic [3:0] fam_maj,
                                             input logic [5:0] fam_min,
                                             input logic [1:0] mask_maj,
                                             input logic [3:0] mask_min);
    cmi_part_id = {fam_maj, fam_min, mask_maj, mask_min};
  endfunction : cmi_part_id

  // ---------------------------------------------------------------
  // Bus responses and types
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    CMI_HOLD    = 2'h0,
    CMI_CAPTURE = 2'h1,
    CMI_RUN     = 2'h3
  } cmi_boot_t;

  typedef struct packed {
    logic               valid;
    logic               hit;
    logic [GADDR_W-1:0] addr;
  } cmi_xlate_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } cmi_wr_t;

endpackage : cmi_pkg

// [design/cmi_page_xlate.sv]
// Translation of local processor and debug addresses to global addresses.
// Assumes requests and the page value come from the same clock domain.
`timescale 1ns/1ns
module cmi_page_xlate
  import cmi_pkg::*;
(
  input  wire logic               aclk,       // System clock
  input  wire logic               aresetn,    // Synchronous reset, low
  input  wire logic               req_valid,  // Local address present
  input  wire logic [LADDR_W-1:0] local_addr, // Local address
  input  wire logic [PAGE_W-1:0]  page,       // Flash page select
  output cmi_xlate_t              xlate       // Registered global address
);

  cmi_xlate_t next_xlate;

  // Window hits take the low four page bits as upper bits, the rest map fixed
  always_comb begin
    next_xlate       = '0;
    next_xlate.valid = req_valid;
    if (req_valid) begin
      if (local_addr >= WIN_FIRST && local_addr <= WIN_LAST) begin
        next_xlate.hit  = 1'b1;
        next_xlate.addr = {page[PAGE_USED_W-1:0],
                           local_addr[WIN_OFS_W-1:0]};
      end else begin
        next_xlate.addr = {FIXED_HIGH, local_addr};
      end
    end
  end

  // Output register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xlate <= '0;
    end else begin
      xlate <= next_xlate;
    end
  end

endmodule : cmi_page_xlate

// [verif/cmi_mode_id_sva.sv]
// Checker for the chip mode and identification block.
// Assumes it is bound to cmi_mode_id and sees only that module's ports.
`timescale 1ns/1ns
module cmi_mode_id_sva
  import cmi_pkg::*;
#(
  parameter logic [3:0] FAM_MAJ  = 4'h1, // Arbitrary value
  parameter logic [5:0] FAM_MIN  = 6'h02, // Arbitrary value
  parameter logic [1:0] MASK_MAJ = 2'h0, // Arbitrary value
  parameter logic [3:0] MASK_MIN = 4'h1  // Arbitrary value
)(
  input wire logic               aclk,              // System clock
  input wire logic               aresetn,           // Sync reset, low
  input wire logic [7:0]         s_axi_araddr,      // Read address
  input wire logic               s_axi_arvalid,     // Read address valid
  input wire logic               s_axi_arready,     // Read address ready
  input wire logic [31:0]        s_axi_rdata,       // Read data
  input wire logic               s_axi_rvalid,      // Read data valid
  input wire logic               cpu_addr_valid,    // Local access valid
  input wire logic [LADDR_W-1:0] cpu_local_addr,    // Local address
  input wire cmi_xlate_t         flash_global,      // Global address
  input wire logic               mode_valid,        // Mode captured
  input wire logic               mode_normal,       // Normal mode
  input wire logic               boot_internal,     // Fetch reset vector
  input wire logic               debug_unit_active, // Debug unit on
  input wire logic               boot_monitor_rom,  // Monitor ROM
  input wire logic               mode_select_input  // Mode strap pin
);
  // ---------------------------------------------------------------
  // Sequences and assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Identifier and mode reads taken on the address channel, and window accesses
  sequence rd_mode_s;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_MODE;
  endsequence
  sequence rd_hi_s;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_PART_ID_HIGH;
  endsequence
  sequence rd_lo_s;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_PART_ID_LOW;
  endsequence
  sequence in_win_s;
    cpu_addr_valid && cpu_local_addr >= WIN_FIRST
      && cpu_local_addr <= WIN_LAST;
  endsequence

  mode_capture_a: assert property
    ($rose(aresetn) |-> ##[1:3] mode_valid)
    else $error("mode not captured after reset release");
  strap_capture_a: assert property
    ($rose(mode_valid) |-> mode_normal == $past(mode_select_input, 3))
    else $error("captured mode differs from strap level");
  mode_read_a: assert property
    (rd_mode_s |=> s_axi_rvalid
      && s_axi_rdata == {31'h0, $past(mode_normal)})
    else $error("mode bit read differs from current mode");
  mode_held_a: assert property (mode_valid |=> mode_valid)
    else $error("captured mode lost without reset");
  mode_decode_a: assert property
    (mode_valid |-> mode_normal ^ debug_unit_active)
    else $error("mode outputs not exactly one of normal or special");
  normal_lock_a: assert property (mode_normal |=> mode_normal)
    else $error("normal mode left without reset");
  boot_path_a: assert property
    (boot_internal == mode_normal && !(boot_internal && boot_monitor_rom))
    else $error("internal boot does not follow normal mode");
  monitor_path_a: assert property
    (boot_monitor_rom == debug_unit_active
      && (mode_valid || !boot_monitor_rom))
    else $error("monitor boot does not follow debug unit");
  id_high_a: assert property (rd_hi_s |=> s_axi_rvalid
    && s_axi_rdata == {24'h0, FAM_MAJ, FAM_MIN[5:2]})
    else $error("identifier high byte wrong");
  id_low_a: assert property (rd_lo_s |=> s_axi_rvalid
    && s_axi_rdata == {24'h0, FAM_MIN[1:0], MASK_MAJ, MASK_MIN})
    else $error("identifier low byte wrong");
  win_hit_a: assert property (in_win_s |=> flash_global.valid
    && flash_global.hit
    && flash_global.addr[13:0] == $past(cpu_local_addr[13:0]))
    else $error("window access not translated");
  win_miss_a: assert property
    (cpu_addr_valid && !(cpu_local_addr >= WIN_FIRST
      && cpu_local_addr <= WIN_LAST)
      |=> !flash_global.hit
      && flash_global.addr == {FIXED_HIGH, $past(cpu_local_addr)})
    else $error("access outside window not mapped fixed");
endmodule : cmi_mode_id_sva

bind cmi_mode_id cmi_mode_id_sva #(
  .FAM_MAJ(FAM_MAJ), .FAM_MIN(FAM_MIN),
  .MASK_MAJ(MASK_MAJ), .MASK_MIN(MASK_MIN)
) sva_u (
  .aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .cpu_addr_valid(cpu_addr_valid), .cpu_local_addr(cpu_local_addr),
  .flash_global(flash_global), .mode_valid(mode_valid),
  .mode_normal(mode_normal), .boot_internal(boot_internal),
  .debug_unit_active(debug_unit_active),
  .boot_monitor_rom(boot_monitor_rom),
  .mode_select_input(mode_select_input)
);

// [verif/tb.sv]
// Self-checking bench for the chip mode and identification block.
// Assumes the bench alone drives every port of cmi_mode_id.
`timescale 1ns/1ns
module tb
  import cmi_pkg::*;
;
  localparam logic [3:0]  FM = 4'h3; // Arbitrary value
  localparam logic [5:0]  FN = 6'h2d; // Arbitrary value
  localparam logic [1:0]  MJ = 2'h2; // Arbitrary value
  localparam logic [3:0]  MN = 4'h9; // Arbitrary value
  localparam logic [15:0] ID = {FM, FN, MJ, MN};

  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, strap;
  logic awready, wready, bvalid, arready, rvalid, mvalid, mnorm;
  logic binternal, dbg, bmon, cvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic [15:0] caddr;
  cmi_xlate_t  fg;
  logic [4:0]  st;
  int mismatches, n_compared;

  cmi_mode_id #(.FAM_MAJ(FM), .FAM_MIN(FN), .MASK_MAJ(MJ), .MASK_MIN(MN))
  dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .mode_select_input(strap),
    .cpu_addr_valid(cvalid), .cpu_local_addr(caddr), .flash_global(fg),
    .mode_valid(mvalid), .mode_normal(mnorm), .boot_internal(binternal),
    .debug_unit_active(dbg), .boot_monitor_rom(bmon));

  // Mode outputs gathered for one compare
  assign st = {mvalid, mnorm, binternal, dbg, bmon};

  // ---------------------------------------------------------------
  // Clock, comparison and verdict
  // ---------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report;
    if (mismatches == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report

  // ---------------------------------------------------------------
  // Bus, reset and translation tasks
  // ---------------------------------------------------------------
  // Write holds each channel until its own ready, then waits response
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    output logic [1:0] rsp);
    logic aw_d;
    logic w_d;
    aw_d = 1'b0;
    w_d  = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!aw_d || !w_d) begin
      @(posedge aclk);
      if (!aw_d && awready) begin
        aw_d = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_d && wready) begin
        w_d = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge aclk);
    rsp = bresp;
    bready <= 1'b0;
  endtask : wr

  // Read holds the address until taken, then waits for data
  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] rsp);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    v = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask : rd

  // Reset with a given strap level; mode settles two edges after release
  task automatic do_reset(input logic s);
    @(posedge aclk);
    aresetn <= 1'b0;
    strap   <= s;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
  endtask : do_reset

  // One local access; the global address is registered one cycle later
  task automatic xl(input logic [15:0] a, input logic [3:0] pg);
    logic in_w;
    in_w = (a >= 16'h8000) && (a <= 16'hbfff);
    @(posedge aclk);
    cvalid <= 1'b1;
    caddr  <= a;
    repeat (2) @(posedge aclk);
    chk(32'(fg), in_w ? {12'h0, 2'b11, pg, a[13:0]}
                      : {12'h0, 2'b10, 2'b11, a});
    cvalid <= 1'b0;
  endtask : xl

  // Read an identifier byte, try to overwrite it, read it again
  task automatic id_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] v;
    logic [1:0]  rsp;
    rd(a, v, rsp);
    chk(v, {24'h0, exp});
    chk(32'(rsp), 32'(RESP_OKAY));
    wr(a, {24'h0, ~exp}, rsp);
    chk(32'(rsp), 32'(RESP_OKAY));
    rd(a, v, rsp);
    chk(v, {24'h0, exp});
  endtask : id_chk

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    aresetn    = 1'b0;
    strap      = 1'b1;
    awvalid    = 1'b0;
    wvalid     = 1'b0;
    bready     = 1'b0;
    arvalid    = 1'b0;
    rready     = 1'b0;
    cvalid     = 1'b0;
    awaddr     = 8'h00;
    araddr     = 8'h00;
    wdata      = 32'h0;
    wstrb      = 4'hf;
    caddr      = 16'h0000;
    mismatches = 0;
    n_compared = 0;
    // Normal mode from a high strap, then locked
    do_reset(1'b1);
    chk(32'(st), 32'h1c);
    rd(ADDR_MODE, d, r);
    chk(d, 32'h1);
    wr(ADDR_MODE, 32'h0, r);
    chk(32'(r), 32'(RESP_OKAY));
    rd(ADDR_MODE, d, r);
    chk(d, 32'h1);
    // Identifier bytes: read, write attempt, read again
    id_chk(ADDR_PART_ID_LOW, ID[7:0]);
    id_chk(ADDR_PART_ID_HIGH, ID[15:8]);
    rd(8'h40, d, r);
    chk(32'(r), 32'(RESP_SLVERR));
    wr(8'h40, 32'h1, r);
    chk(32'(r), 32'(RESP_SLVERR));
    // Page select, strobe gating and translation at the window edges
    wr(ADDR_PAGE, 32'h0a, r);
    rd(ADDR_PAGE, d, r);
    chk(d, 32'h0a);
    wstrb <= 4'he;
    wr(ADDR_PAGE, 32'h05, r);
    wstrb <= 4'hf;
    rd(ADDR_PAGE, d, r);
    chk(d, 32'h0a);
    xl(16'h8000, 4'ha);
    xl(16'hbfff, 4'ha);
    xl(16'h7fff, 4'ha);
    xl(16'hc000, 4'ha);
    wr(ADDR_PAGE, 32'h05, r);
    xl(16'h9234, 4'h5);
    // Special mode from a low strap; software switches once, then locked
    do_reset(1'b0);
    chk(32'(st), 32'h13);
    rd(ADDR_PAGE, d, r);
    chk(d, 32'h0);
    rd(ADDR_MODE, d, r);
    chk(d, 32'h0);
    rd(ADDR_PART_ID_HIGH, d, r);
    chk(d, {24'h0, ID[15:8]});
    wr(ADDR_MODE, 32'h1, r);
    repeat (2) @(posedge aclk);
    chk(32'(st), 32'h1c);
    wr(ADDR_MODE, 32'h0, r);
    rd(ADDR_MODE, d, r);
    chk(d, 32'h1);
    final_report();
  end

  // Watchdog well beyond the hundred or so cycles the scenarios need
  initial begin
    repeat (5000) @(posedge aclk);
    mismatches++;
    final_report();
  end
endmodule : tb
